// [logic/crefc_fine_select.sv]
// Selects one counter channel output as the fine-tune gate.
`timescale 1ns/10ps
`include "crefc_consts.svh"
module crefc_fine_select #(
  parameter int NUM_CHANNELS = `CREFC_CHANNELS
) (
  // Clock and reset.
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  // Counter channel outputs.
  input  wire logic [NUM_CHANNELS-1:0] i_counter_channel_output,
  // Link to the control core.
  crefc_fine_if.sel                    fine
);
  import crefc_pkg::*;

  logic fine_reg;
  logic fine_next;
  logic [NUM_CHANNELS-1:0] hit;

  // =====================================================
  // Channel decode
  // =====================================================
  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : g_ch
      assign hit[g] = (fine.select == 3'(g)) & i_counter_channel_output[g];
    end
  endgenerate

  // Reserved codes match no channel and disabled mode forces off.
  assign fine_next = fine.enable & (|hit);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      fine_reg <= 1'b0;
    end else begin
      fine_reg <= fine_next;
    end
  end

  assign fine.fine_on = fine_reg;

  AST_FINE_OFF_WHEN_DISABLED: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !fine.enable |=> !fine.fine_on) else $error("fine gate on while disabled");
  AST_RESERVED_NO_FINE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (fine.select > 3'h5) |=> !fine.fine_on) else $error("reserved code drove fine");
endmodule

// [logic/crefc_top.sv]
// Control logic of the programmable current reference with fine-tune mode.
//
// Contract
// - Control bit 7 selects source when clear and sink when set.
// - Control bit 6 selects 1 uA steps when clear and 8 uA steps when set.
// - Control bits 5:0 hold the step count and magnitude is step size times count.
// - A zero step count puts the reference into its low power state.
// - In enhanced mode the selected channel output gates an extra two-LSB source.
// - With low bits 00b a constantly high fine signal equals low bits 10b.
// - Configuration bit 7 enables enhanced fine-tune mode.
// - Configuration bits 2:0 pick channel 0 to 5 and other codes are reserved.
// - Configuration bits 6:3 read as zero and ignore writes.
// - Address 0xb9 holds the control register on page 0x0 and configuration on page 0xf.
`timescale 1ns/10ps
`include "crefc_consts.svh"
module crefc_top #(
  parameter int NUM_CHANNELS = `CREFC_CHANNELS
) (
  // Clock and reset.
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  // Special function register bus.
  input  wire logic [7:0]              i_sfr_addr,
  input  wire logic [3:0]              i_sfr_page,
  input  wire logic                    i_sfr_wr,
  input  wire logic                    i_sfr_rd,
  input  wire logic [7:0]              i_sfr_wdata,
  output logic      [7:0]              o_sfr_rdata,
  output logic                         o_sfr_hit,
  // Counter array channel outputs.
  input  wire logic [NUM_CHANNELS-1:0] i_counter_channel_output,
  // Controls to the analog current cell.
  output crefc_pkg::crefc_dir_type     o_direction,
  output crefc_pkg::crefc_range_type   o_output_range_select,
  output logic      [5:0]              o_current_step_count,
  output logic                         o_current_reference_on,
  output logic                         o_fine_source_on,
  output crefc_pkg::crefc_state_type   o_state,
  // Effective magnitude in microamps, for monitoring.
  output logic      [9:0]              o_magnitude_ua
);
  import crefc_pkg::*;

  logic [7:0]      ctrl_reg;
  logic            cfg_en_reg;
  logic [2:0]      cfg_sel_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic [9:0]      mag_reg;
  logic [9:0]      mag_next;
  crefc_state_type state_reg;
  crefc_state_type state_next;
  logic            ctrl_sel;
  logic            cfg_sel;
  logic [6:0]      eff_steps;
  logic [3:0]      step_ua;

  crefc_fine_if fine ();

  // =====================================================
  // Register decode
  // =====================================================
  function automatic logic page_match(input logic [7:0] addr, input logic [3:0] page,
                                      input logic [3:0] want);
    page_match = (addr == `CREFC_REG_ADDR) && (page == want);
  endfunction

  assign ctrl_sel = page_match(i_sfr_addr, i_sfr_page, `CREFC_PAGE_CTRL);
  assign cfg_sel  = page_match(i_sfr_addr, i_sfr_page, `CREFC_PAGE_CFG);
  assign o_sfr_hit = (i_sfr_rd | i_sfr_wr) & (ctrl_sel | cfg_sel);

  // =====================================================
  // Control register
  // =====================================================
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl_reg <= `CREFC_CTRL_RESET;
    end else if (i_sfr_wr && ctrl_sel) begin
      ctrl_reg <= i_sfr_wdata;
    end
  end

  // =====================================================
  // Configuration register
  // =====================================================
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cfg_en_reg  <= 1'(`CREFC_CFG_RESET >> `CREFC_CFG_EN_BIT);
      cfg_sel_reg <= 3'(`CREFC_CFG_RESET);
    end else if (i_sfr_wr && cfg_sel) begin
      cfg_en_reg  <= i_sfr_wdata[`CREFC_CFG_EN_BIT];
      cfg_sel_reg <= i_sfr_wdata[`CREFC_CFG_SEL_MSB:0];
    end
  end

  // =====================================================
  // Read data
  // =====================================================
  always_comb begin
    rdata_next = 8'h00;
    if (ctrl_sel) begin
      rdata_next = ctrl_reg;
    end else if (cfg_sel) begin
      rdata_next = {cfg_en_reg, 4'h0, cfg_sel_reg};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdata_reg <= 8'h00;
    end else if (i_sfr_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_sfr_rdata = rdata_reg;

  // =====================================================
  // Fine-tune channel routing
  // =====================================================
  assign fine.enable = cfg_en_reg;
  assign fine.select = cfg_sel_reg;

  crefc_fine_select #(
    .NUM_CHANNELS(NUM_CHANNELS)
  ) u_fine_select (
    .i_clk                   (i_clk),
    .i_nrst                  (i_nrst),
    .i_counter_channel_output(i_counter_channel_output),
    .fine                    (fine)
  );

  // =====================================================
  // Output state
  // =====================================================
  always_comb begin
    state_next = CREFC_ST_OFF;
    if (ctrl_reg[`CREFC_CTRL_STEP_MSB:0] != 6'h00) begin
      state_next = fine.fine_on ? CREFC_ST_FINE : CREFC_ST_COARSE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= CREFC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Fine source adds two LSBs of weight; zero count keeps it dark.
  always_comb begin
    step_ua   = ctrl_reg[`CREFC_CTRL_RANGE_BIT] ? `CREFC_STEP_HIGH_UA : `CREFC_STEP_LOW_UA;
    eff_steps = {1'b0, ctrl_reg[`CREFC_CTRL_STEP_MSB:0]};
    case (state_next)
      CREFC_ST_FINE: eff_steps = eff_steps + `CREFC_FINE_WEIGHT;
      CREFC_ST_COARSE: eff_steps = eff_steps;
      CREFC_ST_OFF: eff_steps = 7'h00;
      default: eff_steps = 7'h00;
    endcase
    mag_next = 10'(eff_steps * step_ua);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mag_reg <= 10'h000;
    end else begin
      mag_reg <= mag_next;
    end
  end

  assign o_direction            = crefc_dir_type'(ctrl_reg[`CREFC_CTRL_SINK_BIT]);
  assign o_output_range_select  = crefc_range_type'(ctrl_reg[`CREFC_CTRL_RANGE_BIT]);
  assign o_current_step_count   = ctrl_reg[`CREFC_CTRL_STEP_MSB:0];
  assign o_current_reference_on = (state_reg != CREFC_ST_OFF);
  assign o_fine_source_on       = (state_reg == CREFC_ST_FINE);
  assign o_state                = state_reg;
  assign o_magnitude_ua         = mag_reg;

  // =====================================================
  // Assertions
  // =====================================================
  AST_ZERO_COUNT_OFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (ctrl_reg[5:0] == 6'h00) |=> !o_current_reference_on && o_magnitude_ua == 10'h000)
    else $error("zero count did not power down");
  AST_DIR_FOLLOWS_WRITE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_wr && ctrl_sel) |=> (o_direction == crefc_dir_type'($past(i_sfr_wdata[7]))))
    else $error("direction not taken from bit 7");
  AST_RANGE_FOLLOWS_WRITE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_wr && ctrl_sel) |=> (o_output_range_select ==
    crefc_range_type'($past(i_sfr_wdata[6])))) else $error("range not taken from bit 6");
  AST_STEP_FOLLOWS_WRITE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_wr && ctrl_sel) |=> (o_current_step_count == $past(i_sfr_wdata[5:0])))
    else $error("step count not taken from bits 5 to 0");
  AST_COARSE_MAG: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_next == CREFC_ST_COARSE) |=> o_magnitude_ua ==
    10'($past(ctrl_reg[5:0]) * (($past(ctrl_reg[6])) ? 8 : 1)))
    else $error("coarse magnitude wrong");
  AST_HIGH_STEP_MULT: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_next != CREFC_ST_OFF && ctrl_reg[6]) |=> (o_magnitude_ua[2:0] == 3'h0))
    else $error("high range magnitude not a multiple of eight");
  AST_FINE_MAG: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_next == CREFC_ST_FINE) |=> o_magnitude_ua ==
    10'(({1'b0, $past(ctrl_reg[5:0])} + 7'h02) * (($past(ctrl_reg[6])) ? 8 : 1)))
    else $error("fine source did not add two steps");
  AST_FINE_EQ_TEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_next == CREFC_ST_FINE && ctrl_reg[1:0] == 2'b00) |=> o_magnitude_ua ==
    10'({1'b0, $past(ctrl_reg[5:2]), 2'b10} * (($past(ctrl_reg[6])) ? 8 : 1)))
    else $error("fine weight not two LSBs");
  AST_MAG_OFF_WHEN_OFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_state == CREFC_ST_OFF) |-> (o_magnitude_ua == 10'h000))
    else $error("magnitude nonzero in low power state");
  AST_ON_MAG_NONZERO: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_current_reference_on |-> (o_magnitude_ua != 10'h000))
    else $error("reference on with zero magnitude");
  // The reset qualifier keeps the check from looking back across a reset edge.
  AST_ON_FOLLOWS_COUNT: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($past(i_nrst) && $past(o_current_step_count) != 6'h00) |-> o_current_reference_on)
    else $error("nonzero count left reference off");
  AST_FINE_NEEDS_COUNT: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_fine_source_on |-> ($past(o_current_step_count) != 6'h00))
    else $error("fine source on with zero count");
  AST_FINE_STATE_FROM_GATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_state == CREFC_ST_FINE) |-> $past(fine.fine_on))
    else $error("fine state without fine gate");
  AST_COARSE_STATE_NO_GATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (o_state == CREFC_ST_COARSE) |-> !$past(fine.fine_on))
    else $error("coarse state while fine gate on");
  AST_FINE_NEEDS_EN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !cfg_en_reg [*3] |-> !o_fine_source_on)
    else $error("fine source on with mode disabled");
  AST_ROUTE_CHANNEL: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cfg_en_reg && cfg_sel_reg < 3'h6 && i_counter_channel_output[cfg_sel_reg]
    && $stable(cfg_sel_reg) && $stable(cfg_en_reg)) |=> fine.fine_on)
    else $error("selected channel not routed");
  // The gate and the state register give two edges from select to output.
  AST_RESERVED_DARK: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cfg_sel_reg > 3'h5) |-> ##2 !o_fine_source_on)
    else $error("reserved select lit the fine source");

  // =====================================================
  // Register bus assertions
  // =====================================================
  AST_HIT_DECODE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_sfr_hit == ((i_sfr_rd || i_sfr_wr) && i_sfr_addr == `CREFC_REG_ADDR
    && (i_sfr_page == `CREFC_PAGE_CTRL || i_sfr_page == `CREFC_PAGE_CFG)))
    else $error("register hit decode wrong");
  AST_PAGE_SEPARATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_wr && cfg_sel) |=> $stable(ctrl_reg))
    else $error("config write hit control register");
  AST_CTRL_HOLDS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(i_sfr_wr && ctrl_sel) |=> $stable(ctrl_reg))
    else $error("control register changed without a write");
  AST_CFG_HOLDS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(i_sfr_wr && cfg_sel) |=> $stable({cfg_en_reg, cfg_sel_reg}))
    else $error("config register changed without a write");
  AST_EN_FOLLOWS_WRITE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_wr && cfg_sel) |=> (cfg_en_reg == $past(i_sfr_wdata[7])))
    else $error("fine enable not taken from bit 7");
  AST_SEL_FOLLOWS_WRITE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_wr && cfg_sel) |=> (cfg_sel_reg == $past(i_sfr_wdata[2:0])))
    else $error("fine select not taken from bits 2 to 0");
  AST_CTRL_READBACK: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_rd && ctrl_sel) |=> (o_sfr_rdata == $past(ctrl_reg)))
    else $error("control read data wrong");
  AST_CFG_READBACK: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_rd && cfg_sel) |=> (o_sfr_rdata[7] == $past(cfg_en_reg)
    && o_sfr_rdata[2:0] == $past(cfg_sel_reg)))
    else $error("config read data wrong");
  AST_CFG_READ_ZERO: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_rd && cfg_sel) |=> o_sfr_rdata[6:3] == 4'h0)
    else $error("unused config bits read nonzero");
  AST_UNMAPPED_READ_ZERO: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_rd && !ctrl_sel && !cfg_sel) |=> (o_sfr_rdata == 8'h00))
    else $error("unmapped read returned data");
  AST_RDATA_HOLDS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");
  // Reset itself is watched here, so no reset disable applies.
  AST_RESET_CLEARS: assert property (@(posedge i_clk)
    !i_nrst |=> (ctrl_reg == `CREFC_CTRL_RESET && {cfg_en_reg, 4'h0, cfg_sel_reg} ==
    `CREFC_CFG_RESET && o_sfr_rdata == 8'h00 && o_state == CREFC_ST_OFF))
    else $error("reset did not clear the registers");

  // =====================================================
  // Coverage
  // =====================================================
  COV_FINE_ACTIVE: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_fine_source_on);
  COV_SINK_HIGH: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_direction == CREFC_SINK && o_output_range_select == CREFC_RANGE_HIGH);
  COV_DISABLE_WRITE: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_current_reference_on ##1 (i_sfr_wr && ctrl_sel && i_sfr_wdata == 8'h00));
  COV_RESERVED_SELECT: cover property (@(posedge i_clk) disable iff (!i_nrst)
    cfg_en_reg && cfg_sel_reg > 3'h5);
  COV_FINE_FULL_SCALE: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_fine_source_on && o_current_step_count == 6'h3f
    && o_output_range_select == CREFC_RANGE_HIGH);
endmodule

// [pkg/crefc_consts.svh]
// Register addresses, pages, field positions and reset values for the current reference control.
`ifndef CREFC_CONSTS_SVH
`define CREFC_CONSTS_SVH

`define CREFC_REG_ADDR       8'hb9
`define CREFC_PAGE_CTRL      4'h0
`define CREFC_PAGE_CFG       4'hf
`define CREFC_CTRL_RESET     8'h00
`define CREFC_CFG_RESET      8'h00
`define CREFC_CTRL_SINK_BIT  7
`define CREFC_CTRL_RANGE_BIT 6
`define CREFC_CTRL_STEP_MSB  5
`define CREFC_CFG_EN_BIT     7
`define CREFC_CFG_SEL_MSB    2
`define CREFC_CHANNELS       6
`define CREFC_FINE_WEIGHT    7'h02
`define CREFC_STEP_LOW_UA    4'h1
`define CREFC_STEP_HIGH_UA   4'h8

`endif

// [pkg/crefc_fine_if.sv]
// Fine-tune routing signals passed between the control core and the channel selector.
`timescale 1ns/10ps
interface crefc_fine_if;
  logic       enable;
  logic [2:0] select;
  logic       fine_on;

  modport ctrl (
    output enable,
    output select,
    input  fine_on
  );

  modport sel (
    input  enable,
    input  select,
    output fine_on
  );
endinterface

// [pkg/crefc_pkg.sv]
// Types shared by the current reference control modules.
package crefc_pkg;

  typedef enum logic {
    CREFC_SOURCE,
    CREFC_SINK
  } crefc_dir_type;

  typedef enum logic {
    CREFC_RANGE_LOW,
    CREFC_RANGE_HIGH
  } crefc_range_type;

  typedef enum logic [1:0] {
    CREFC_ST_OFF,
    CREFC_ST_COARSE,
    CREFC_ST_FINE
  } crefc_state_type;

endpackage

// [verif/crefc_bench.sv]
// Self-checking bench for the current reference control.
`timescale 1ns/10ps
`include "crefc_consts.svh"
module crefc_bench;
  import crefc_pkg::*;
  // ==========================================================
  // Signals
  logic            i_clk = 1'b0;
  logic            i_nrst = 1'b0;
  logic [7:0]      i_sfr_addr = 8'h00;
  logic [3:0]      i_sfr_page = 4'h0;
  logic            i_sfr_wr = 1'b0;
  logic            i_sfr_rd = 1'b0;
  logic [7:0]      i_sfr_wdata = 8'h00;
  logic [7:0]      o_sfr_rdata;
  logic            o_sfr_hit;
  logic [5:0]      level = 6'h00;
  logic [5:0]      chan;
  crefc_dir_type   o_direction;
  crefc_range_type o_output_range_select;
  logic [5:0]      o_current_step_count;
  logic            o_current_reference_on;
  logic            o_fine_source_on;
  crefc_state_type o_state;
  logic [9:0]      o_magnitude_ua;
  int              n_mismatch = 0;
  int              checks = 0;

  always #4 i_clk = ~i_clk;

  crefc_pca_model pca (
    .i_clk                    (i_clk),
    .i_level                  (level),
    .o_counter_channel_output (chan)
  );

  crefc_top dut (
    .i_clk                    (i_clk),
    .i_nrst                   (i_nrst),
    .i_sfr_addr               (i_sfr_addr),
    .i_sfr_page               (i_sfr_page),
    .i_sfr_wr                 (i_sfr_wr),
    .i_sfr_rd                 (i_sfr_rd),
    .i_sfr_wdata              (i_sfr_wdata),
    .o_sfr_rdata              (o_sfr_rdata),
    .o_sfr_hit                (o_sfr_hit),
    .i_counter_channel_output (chan),
    .o_direction              (o_direction),
    .o_output_range_select    (o_output_range_select),
    .o_current_step_count     (o_current_step_count),
    .o_current_reference_on   (o_current_reference_on),
    .o_fine_source_on         (o_fine_source_on),
    .o_state                  (o_state),
    .o_magnitude_ua           (o_magnitude_ua)
  );

  // ==========================================================
  // Tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One strobe cycle; the hit flag is looked at while the strobe stands.
  task automatic access(input logic w, input logic [3:0] pg, input logic [7:0] ad,
                        input logic [7:0] d);
    @(negedge i_clk);
    i_sfr_page = pg;
    i_sfr_addr = ad;
    i_sfr_wdata = d;
    i_sfr_wr = w;
    i_sfr_rd = ~w;
    #1;
    chk(10'(o_sfr_hit), 10'((ad == 8'hb9) && (pg == 4'h0 || pg == 4'hf)));
    @(negedge i_clk);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
  endtask

  task automatic wr(input logic [3:0] pg, input logic [7:0] d);
    access(1'b1, pg, 8'hb9, d);
    repeat (4) @(negedge i_clk);
  endtask

  task automatic rd(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] exp);
    access(1'b0, pg, ad, 8'h00);
    chk(10'(o_sfr_rdata), 10'(exp));
  endtask

  // Analog controls expected from count, fine gate and step size in microamps.
  task automatic expect_out(input logic [5:0] c, input logic f, input logic [9:0] step);
    crefc_state_type st;
    st = (c == 6'h00) ? CREFC_ST_OFF : (f ? CREFC_ST_FINE : CREFC_ST_COARSE);
    chk(10'(o_current_step_count), 10'(c));
    chk(10'(o_current_reference_on), 10'(c != 6'h00));
    chk(10'(o_fine_source_on), 10'(f));
    chk(10'(o_state), 10'(st));
    chk(o_magnitude_ua, (c == 6'h00) ? 10'h000 : step * (10'(c) + (f ? 10'h002 : 10'h000)));
  endtask

  // ==========================================================
  // Sequence
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end

  initial begin
    repeat (3) @(negedge i_clk);
    i_nrst = 1'b1;
    rd(4'h0, 8'hb9, 8'h00);
    rd(4'hf, 8'hb9, 8'h00);
    expect_out(6'h00, 1'b0, 10'h001);
    wr(4'h0, 8'h85);
    chk(10'(o_direction), 10'(CREFC_SINK));
    chk(10'(o_output_range_select), 10'(CREFC_RANGE_LOW));
    expect_out(6'h05, 1'b0, 10'h001);
    wr(4'h0, 8'h4a);
    chk(10'(o_direction), 10'(CREFC_SOURCE));
    chk(10'(o_output_range_select), 10'(CREFC_RANGE_HIGH));
    expect_out(6'h0a, 1'b0, 10'h008);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'hb9, 8'h87);
    rd(4'h0, 8'hb9, 8'h4a);
    rd(4'h0, 8'hba, 8'h00);
    rd(4'h3, 8'hb9, 8'h00);
    level = 6'h3f;
    wr(4'h0, 8'h04);
    expect_out(6'h04, 1'b0, 10'h001);
    wr(4'hf, 8'h86);
    expect_out(6'h04, 1'b0, 10'h001);
    for (int i = 0; i < 6; i++) begin
      wr(4'hf, 8'h80 | 8'(i));
      level = ~(6'h01 << i);
      repeat (4) @(negedge i_clk);
      expect_out(6'h04, 1'b0, 10'h001);
      level = 6'h01 << i;
      repeat (4) @(negedge i_clk);
      expect_out(6'h04, 1'b1, 10'h001);
    end
    wr(4'h0, 8'h44);
    expect_out(6'h04, 1'b1, 10'h008);
    wr(4'hf, 8'h05);
    expect_out(6'h04, 1'b0, 10'h008);
    wr(4'h0, 8'h06);
    expect_out(6'h06, 1'b0, 10'h001);
    wr(4'hf, 8'h85);
    wr(4'h0, 8'hff);
    chk(10'(o_direction), 10'(CREFC_SINK));
    chk(10'(o_output_range_select), 10'(CREFC_RANGE_HIGH));
    expect_out(6'h3f, 1'b1, 10'h008);
    wr(4'h0, 8'h00);
    expect_out(6'h00, 1'b0, 10'h001);
    rd(4'h0, 8'hb9, 8'h00);
    // A mid-run reset must clear both registers and the output state.
    wr(4'h0, 8'hc3);
    i_nrst = 1'b0;
    repeat (3) @(negedge i_clk);
    i_nrst = 1'b1;
    chk(10'(o_direction), 10'(CREFC_SOURCE));
    chk(10'(o_output_range_select), 10'(CREFC_RANGE_LOW));
    expect_out(6'h00, 1'b0, 10'h001);
    rd(4'hf, 8'hb9, 8'h00);
    rd(4'h0, 8'hb9, 8'h00);
    test_done;
  end
endmodule

// [verif/crefc_pca_model.sv]
// Behavioural counter array model that drives the six channel outputs.
`timescale 1ns/10ps
module crefc_pca_model (
  // Clock.
  input  wire logic       i_clk,
  // Levels requested by the bench.
  input  wire logic [5:0] i_level,
  // Channel outputs.
  output logic      [5:0] o_counter_channel_output
);
  initial begin
    o_counter_channel_output = 6'h00;
  end

  // Levels change only just after a clock edge, as the real counter does.
  always @(posedge i_clk) begin
    o_counter_channel_output <= i_level;
  end
endmodule
